//--- logic/ltd_alu.sv
// Combinational arithmetic unit: add, subtract, logic ops and decimal adjust.
`timescale 1ns/1ps
`include "ltd_params.svh"
module ltd_alu (
  ltd_alu_if.alu bus
);
  import ltd_pkg::*;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] b_eff;
  logic carry_in;
  logic low_fix;
  logic [4:0] low_adj;
  logic [4:0] high_sum;
  logic [4:0] high_adj;
  logic [7:0] res;
  logic [4:0] fl;
  // Subtraction is a + ~b + 1, so carry reads as "no borrow".
  assign b_eff = (bus.op == LTD_ALU_SUB) ? ~bus.b : bus.b;
  assign carry_in = (bus.op == LTD_ALU_SUB);
  assign sum = {1'b0, bus.a} + {1'b0, b_eff} + {8'h00, carry_in};
  assign low_sum = {1'b0, bus.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
  assign low_fix = (bus.a[3:0] > 4'h9) || bus.digit_carry_in;
  assign low_adj = {1'b0, bus.a[3:0]} + (low_fix ? 5'h06 : 5'h00);
  // The high test includes the low carry, so a 9 plus carry is still fixed up.
  assign high_sum = {1'b0, bus.a[7:4]} + {4'h0, low_adj[4]};
  assign high_adj = high_sum + (((high_sum > 5'h09) || bus.c_in) ? 5'h06 : 5'h00);
  always_comb
  begin
    res = 8'h00;
    fl = 5'h00;
    case (bus.op)
      LTD_ALU_ADD, LTD_ALU_SUB:
      begin
        res = sum[7:0];
        fl[`LTD_FLAG_C] = sum[8];
        fl[`LTD_FLAG_DIGIT_CARRY] = low_sum[4];
        fl[`LTD_FLAG_OVERFLOW] = (bus.a[7] == b_eff[7]) && (sum[7] != bus.a[7]);
      end
      LTD_ALU_AND: res = bus.a & bus.b;
      LTD_ALU_OR: res = bus.a | bus.b;
      LTD_ALU_XOR: res = bus.a ^ bus.b;
      LTD_ALU_DAW:
      begin
        res = {high_adj[3:0], low_adj[3:0]};
        fl[`LTD_FLAG_C] = high_adj[4] || bus.c_in;
      end
      default: res = 8'h00;
    endcase
    fl[`LTD_FLAG_Z] = (res == 8'h00);
    fl[`LTD_FLAG_N] = res[7];
  end
  assign bus.result = res;
  assign bus.flags = fl;
endmodule

//--- logic/ltd_alu_if.sv
// Operand and result bundle between the decoder and its arithmetic unit.
`timescale 1ns/1ps
interface ltd_alu_if;
  import ltd_pkg::*;
  ltd_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic c_in;
  logic digit_carry_in;
  logic [7:0] result;
  logic [4:0] flags;
  modport core (output op, output a, output b, output c_in, output digit_carry_in,
                input result, input flags);
  modport alu (input op, input a, input b, input c_in, input digit_carry_in,
               output result, output flags);
endinterface

//--- logic/ltd_decoder.sv
// Literal, table, decimal-adjust, decrement, move and bank-load decode and execute.
`timescale 1ns/1ps
`include "ltd_params.svh"
module ltd_decoder (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Instruction fetch
  input wire logic [15:0] insn_word,
  input wire logic insn_valid,
  output logic insn_ready,
  output logic pipe_flush,
  output logic return_pop,
  // Register file
  output logic [11:0] rf_addr,
  output logic rf_read,
  input wire logic [7:0] rf_rdata,
  input wire logic [7:0] pin_levels,
  output logic rf_write,
  output logic [11:0] rf_waddr,
  output logic [7:0] rf_wdata,
  // Timer zero
  input wire logic prescaler_assigned,
  output logic prescaler_clear,
  // Table access to program memory
  output logic [20:0] tbl_addr,
  output logic tbl_read,
  output logic tbl_write,
  input wire logic [7:0] tbl_rdata,
  output logic [7:0] tbl_latch,
  output logic [20:0] table_ptr,
  // Core state
  output logic [7:0] working_register,
  output logic [4:0] status_flags,
  output logic [7:0] bank_select_reg,
  output logic [35:0] indirect_pointer_reg,
  output logic [15:0] product
);
  import ltd_pkg::*;
  ltd_alu_if alu_bus ();
  ltd_alu u_alu (.bus(alu_bus));

  function automatic logic is_port(input logic [11:0] addr);
    is_port = (addr >= `LTD_PORT_FIRST) && (addr <= `LTD_PORT_LAST);
  endfunction

  function automatic logic is_guarded(input logic [11:0] addr);
    is_guarded = (addr == `LTD_PC_LOW_ADDR) || (addr >= `LTD_STACK_FIRST);
  endfunction

  ltd_state_t state;
  ltd_state_t next_state;
  logic [11:0] move_dest_pending;
  logic [7:0] move_data;
  logic tbl_rd_pending;
  logic [1:0] ptr_sel;
  logic [3:0] ptr_high;

  wire [7:0] hi = insn_word[15:8];
  wire [7:0] k = insn_word[7:0];
  wire exec = insn_valid && (state == LTD_ST_EXEC);
  wire op_add = exec && (hi == `LTD_OP_ADD_LIT);
  wire op_and = exec && (hi == `LTD_OP_AND_LIT);
  wire op_or = exec && (hi == `LTD_OP_OR_LIT);
  wire op_xor = exec && (hi == `LTD_OP_XOR_LIT);
  wire op_load = exec && (hi == `LTD_OP_LOAD_LIT);
  wire op_mul = exec && (hi == `LTD_OP_MUL_LIT);
  wire op_ret = exec && (hi == `LTD_OP_RET_LIT);
  wire op_sub = exec && (hi == `LTD_OP_SUB_LIT);
  wire op_bank = exec && (hi == `LTD_OP_BANK_LOAD);
  wire op_ptr = exec && (hi == `LTD_OP_PTR_FIRST) && (insn_word[7:6] == 2'b00);
  wire op_dec = exec && (insn_word[15:10] == `LTD_OP_DEC_TOP);
  wire op_move = exec && (insn_word[15:12] == `LTD_OP_MOVE_TOP);
  wire op_tbl_rd = exec && (insn_word[15:2] == `LTD_OP_TBL_RD_TOP);
  wire op_tbl_wr = exec && (insn_word[15:2] == `LTD_OP_TBL_WR_TOP);
  wire op_daw = exec && (insn_word == `LTD_OP_DEC_ADJ);
  wire op_tbl = op_tbl_rd || op_tbl_wr;
  wire [1:0] tbl_mode = insn_word[1:0];
  // word two consumed only after word one
  wire take_second = insn_valid && ((state == LTD_ST_PTR2) || (state == LTD_ST_MOVE2));
  wire [11:0] move_dest = insn_word[11:0];
  wire move_write_ok = take_second && (state == LTD_ST_MOVE2) && !is_guarded(move_dest);

  wire [11:0] dec_addr = insn_word[8]
    ? {bank_select_reg[3:0], k}
    : ((k < `LTD_ACCESS_SPLIT) ? {4'h0, k} : {`LTD_ACCESS_HIGH, k});
  assign rf_addr = op_move ? insn_word[11:0] : dec_addr;
  assign rf_read = op_dec || op_move;
  wire [7:0] operand = is_port(rf_addr) ? pin_levels : rf_rdata;

  assign alu_bus.op = op_and ? LTD_ALU_AND : op_or ? LTD_ALU_OR : op_xor ? LTD_ALU_XOR
    : op_daw ? LTD_ALU_DAW : (op_sub || op_dec) ? LTD_ALU_SUB : LTD_ALU_ADD;
  assign alu_bus.a = op_dec ? operand : (op_daw ? working_register : k);
  assign alu_bus.b = op_dec ? 8'h01 : working_register;
  assign alu_bus.c_in = status_flags[`LTD_FLAG_C];
  assign alu_bus.digit_carry_in = status_flags[`LTD_FLAG_DIGIT_CARRY];

  wire [4:0] flag_mask = (op_add || op_sub || op_dec) ? `LTD_FLAGS_ALL
    : (op_and || op_or || op_xor) ? `LTD_FLAGS_ZN : op_daw ? `LTD_FLAGS_C : `LTD_FLAGS_NONE;
  wire w_from_alu = op_add || op_sub || op_and || op_or || op_xor || op_daw
    || (op_dec && !insn_word[9]);
  wire [7:0] next_w = w_from_alu ? alu_bus.result : ((op_load || op_ret) ? k : working_register);
  wire [4:0] next_flags = (status_flags & ~flag_mask) | (alu_bus.flags & flag_mask);
  wire dec_write = op_dec && insn_word[9];
  wire next_rf_write = dec_write || move_write_ok;
  wire [11:0] next_waddr = dec_write ? dec_addr : move_dest;

  assign tbl_addr = (tbl_mode == `LTD_TBL_PRE_INC) ? table_ptr + 21'h1 : table_ptr;
  assign tbl_read = op_tbl_rd;
  assign tbl_write = op_tbl_wr;
  wire [20:0] next_table_ptr = !op_tbl ? table_ptr
    : (tbl_mode == `LTD_TBL_POST_DEC) ? table_ptr - 21'h1
    : (tbl_mode == `LTD_TBL_POST_INC || tbl_mode == `LTD_TBL_PRE_INC)
      ? table_ptr + 21'h1 : table_ptr;

  // pointer load waits for word two
  always_comb
  begin
    next_state = state;
    case (state)
      LTD_ST_EXEC:
      begin
        if (op_ptr)
          next_state = LTD_ST_PTR2;
        else if (op_move)
          next_state = LTD_ST_MOVE2;
        else if (op_ret || op_tbl)
          next_state = LTD_ST_NOP2;
        else
          next_state = LTD_ST_EXEC;
      end
      LTD_ST_PTR2, LTD_ST_MOVE2: next_state = insn_valid ? LTD_ST_EXEC : state;
      LTD_ST_NOP2: next_state = LTD_ST_EXEC;
      default: next_state = LTD_ST_EXEC;
    endcase
  end

  // The fetch holds its word during the no-op cycle so nothing is skipped.
  assign insn_ready = (state != LTD_ST_NOP2);
  assign pipe_flush = op_ret;
  assign return_pop = op_ret;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= LTD_ST_EXEC;
      working_register <= 8'h00;
      status_flags <= 5'h00;
      table_ptr <= 21'h000000;
      move_data <= 8'h00;
      tbl_rd_pending <= 1'b0;
      ptr_sel <= 2'h0;
      ptr_high <= 4'h0;
    end
    else
    begin
      state <= next_state;
      working_register <= next_w;
      status_flags <= next_flags;
      table_ptr <= next_table_ptr;
      if (op_move)
        move_data <= operand;
      tbl_rd_pending <= op_tbl_rd;
      if (op_ptr)
      begin
        ptr_sel <= insn_word[5:4];
        ptr_high <= insn_word[3:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rf_write <= 1'b0;
      rf_waddr <= 12'h000;
      rf_wdata <= 8'h00;
      prescaler_clear <= 1'b0;
      tbl_latch <= 8'h00;
      product <= 16'h0000;
      bank_select_reg <= 8'h00;
      indirect_pointer_reg <= 36'h000000000;
    end
    else
    begin
      rf_write <= next_rf_write;
      rf_waddr <= next_waddr;
      rf_wdata <= dec_write ? alu_bus.result : move_data;
      prescaler_clear <= next_rf_write && (next_waddr == `LTD_TIMER0_ADDR) && prescaler_assigned;
      if (tbl_rd_pending)
        tbl_latch <= tbl_rdata;
      if (op_mul)
        product <= k * working_register;
      if (op_bank)
        bank_select_reg <= {4'h0, k[3:0]};
      if (take_second && state == LTD_ST_PTR2 && ptr_sel != `LTD_PTR_INVALID)
        indirect_pointer_reg[ptr_sel * 12 +: 12] <= {ptr_high, insn_word[7:0]};
    end
  end

  logic [7:0] past_k;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      past_k <= 8'h00;
    else
      past_k <= k;
  end

  chk_add_result: assert property (@(posedge clock) disable iff (!reset_n)
    op_add |=> working_register == $past(k) + $past(working_register))
    else $error("add literal result wrong");
  chk_logic_flags: assert property (@(posedge clock) disable iff (!reset_n)
    (op_and || op_or || op_xor) |=> status_flags == {working_register[7],
      $past(status_flags[3]), working_register == 8'h00, $past(status_flags[1:0])})
    else $error("logic op flags wrong");
  chk_load_flags: assert property (@(posedge clock) disable iff (!reset_n)
    op_load |=> working_register == past_k && $stable(status_flags))
    else $error("literal load wrong");
  chk_mul_product: assert property (@(posedge clock) disable iff (!reset_n)
    op_mul |=> product == past_k * $past(working_register))
    else $error("multiply product wrong");
  chk_ret_cycles: assert property (@(posedge clock) disable iff (!reset_n)
    op_ret |=> state == LTD_ST_NOP2 && !insn_ready ##1 insn_ready)
    else $error("return not two cycles");
  chk_bank_upper: assert property (@(posedge clock) disable iff (!reset_n)
    op_bank |=> bank_select_reg == {4'h0, past_k[3:0]})
    else $error("bank upper bits not zero");
  chk_tbl_postinc: assert property (@(posedge clock) disable iff (!reset_n)
    (op_tbl_rd && tbl_mode == `LTD_TBL_POST_INC) |=> table_ptr == $past(table_ptr) + 21'h1)
    else $error("table post-increment wrong");
  chk_lone_second: assert property (@(posedge clock) disable iff (!reset_n)
    (exec && insn_word[15:12] == `LTD_OP_SECOND_TOP) |=> $stable(working_register) && !rf_write)
    else $error("lone second word not a no-op");
  chk_move_write: assert property (@(posedge clock) disable iff (!reset_n)
    (op_move ##1 move_write_ok) |=> rf_write && rf_wdata == $past(move_data, 1))
    else $error("move write missing or wrong data");
  chk_prescaler_clr: assert property (@(posedge clock) disable iff (!reset_n)
    (rf_write && rf_waddr == `LTD_TIMER0_ADDR) |-> prescaler_clear == $past(prescaler_assigned))
    else $error("prescaler clear wrong");
endmodule

//--- logic/ltd_params.svh
// Opcode encodings, register addresses and flag positions for the literal/table decoder.
`ifndef LTD_PARAMS_SVH
`define LTD_PARAMS_SVH
`define LTD_OP_ADD_LIT 8'h0f
`define LTD_OP_AND_LIT 8'h0b
`define LTD_OP_OR_LIT 8'h09
`define LTD_OP_XOR_LIT 8'h0a
`define LTD_OP_LOAD_LIT 8'h0e
`define LTD_OP_MUL_LIT 8'h0d
`define LTD_OP_RET_LIT 8'h0c
`define LTD_OP_SUB_LIT 8'h08
`define LTD_OP_BANK_LOAD 8'h01
`define LTD_OP_PTR_FIRST 8'hee
`define LTD_OP_PTR_SECOND 8'hf0
`define LTD_OP_DEC_TOP 6'h01
`define LTD_OP_MOVE_TOP 4'hc
`define LTD_OP_SECOND_TOP 4'hf
`define LTD_OP_TBL_RD_TOP 14'h0002
`define LTD_OP_TBL_WR_TOP 14'h0003
`define LTD_OP_DEC_ADJ 16'h0007
`define LTD_TBL_POST_INC 2'h1
`define LTD_TBL_POST_DEC 2'h2
`define LTD_TBL_PRE_INC 2'h3
`define LTD_ACCESS_SPLIT 8'h60
`define LTD_ACCESS_HIGH 4'hf
`define LTD_PORT_FIRST 12'hf80
`define LTD_PORT_LAST 12'hf84
`define LTD_TIMER0_ADDR 12'hfd6
`define LTD_PC_LOW_ADDR 12'hff9
`define LTD_STACK_FIRST 12'hffd
`define LTD_FLAG_C 0
`define LTD_FLAG_DIGIT_CARRY 1
`define LTD_FLAG_Z 2
`define LTD_FLAG_OVERFLOW 3
`define LTD_FLAG_N 4
`define LTD_FLAGS_ALL 5'h1f
`define LTD_FLAGS_ZN 5'h14
`define LTD_FLAGS_C 5'h01
`define LTD_FLAGS_NONE 5'h00
`define LTD_PTR_INVALID 2'h3
`endif

//--- logic/ltd_pkg.sv
// Types shared by the literal/table decoder and its arithmetic unit.
package ltd_pkg;
  typedef enum logic [2:0]
  {
    LTD_ALU_ADD = 3'h0,
    LTD_ALU_SUB = 3'h1,
    LTD_ALU_AND = 3'h2,
    LTD_ALU_OR = 3'h3,
    LTD_ALU_XOR = 3'h4,
    LTD_ALU_DAW = 3'h5
  } ltd_alu_op_t;
  typedef enum logic [1:0]
  {
    LTD_ST_EXEC = 2'b00,
    LTD_ST_PTR2 = 2'b01,
    LTD_ST_MOVE2 = 2'b11,
    LTD_ST_NOP2 = 2'b10
  } ltd_state_t;
endpackage

//--- testbench/ltd_far_model.sv
// Register file and program memory stand-in facing the decoder.
`timescale 1ns/1ps
module ltd_far_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register file
  input wire logic [11:0] rf_addr,
  input wire logic rf_read,
  output logic [7:0] rf_rdata,
  // Program memory
  input wire logic [20:0] tbl_addr,
  input wire logic tbl_read,
  output logic [7:0] tbl_rdata
);
  logic [7:0] idle_pat;
  logic [7:0] tbl_hold;
  logic tbl_due;
  // Unselected data lines wander each cycle so a stale value is never trusted.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_pat <= 8'h00;
      tbl_hold <= 8'h00;
      tbl_due <= 1'b0;
    end
    else
    begin
      idle_pat <= idle_pat + 8'h3b;
      tbl_hold <= tbl_addr[7:0] ^ 8'h3c;
      tbl_due <= tbl_read;
    end
  end
  assign rf_rdata = rf_read ? (rf_addr[7:0] ^ 8'h5a) : idle_pat;
  assign tbl_rdata = tbl_due ? tbl_hold : ~idle_pat;
endmodule

//--- testbench/tb_literal_table_insn_decode.sv
// Self-checking bench for the literal and table instruction decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_literal_table_insn_decode;
  logic clock, reset_n, insn_valid, insn_ready, pipe_flush, return_pop;
  logic rf_read, rf_write, prescaler_assigned, prescaler_clear, tbl_read, tbl_write;
  logic [15:0] insn_word, product;
  logic [11:0] rf_addr, rf_waddr;
  logic [7:0] rf_rdata, pin_levels, rf_wdata, tbl_rdata, tbl_latch;
  logic [7:0] working_register, bank_select_reg;
  logic [20:0] tbl_addr, table_ptr, ptr, exp_addr;
  logic [4:0] status_flags;
  logic [35:0] indirect_pointer_reg;
  int errors, checks;
  // Row: start register, instruction, expected register, flags {neg, ovf, zero, dcarry, carry}.
  logic [36:0] rows [8] = '{
    {8'h01, 16'h0fff, 8'h00, 5'h07}, {8'hff, 16'h0b0f, 8'h0f, 5'h03},
    {8'h80, 16'h0901, 8'h81, 5'h13}, {8'haa, 16'h0aaa, 8'h00, 5'h07},
    {8'h01, 16'h0800, 8'hff, 5'h10}, {8'ha5, 16'h0007, 8'h05, 5'h11},
    {8'h12, 16'h0e34, 8'h34, 5'h11}, {8'h01, 16'h0f7f, 8'h80, 5'h1a}};
  ltd_decoder u_dut (.clock(clock), .reset_n(reset_n), .insn_word(insn_word),
    .insn_valid(insn_valid), .insn_ready(insn_ready), .pipe_flush(pipe_flush),
    .return_pop(return_pop), .rf_addr(rf_addr), .rf_read(rf_read), .rf_rdata(rf_rdata),
    .pin_levels(pin_levels), .rf_write(rf_write), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .prescaler_assigned(prescaler_assigned), .prescaler_clear(prescaler_clear),
    .tbl_addr(tbl_addr), .tbl_read(tbl_read), .tbl_write(tbl_write), .tbl_rdata(tbl_rdata),
    .tbl_latch(tbl_latch), .table_ptr(table_ptr), .working_register(working_register),
    .status_flags(status_flags), .bank_select_reg(bank_select_reg),
    .indirect_pointer_reg(indirect_pointer_reg), .product(product));
  ltd_far_model u_far (.clock(clock), .reset_n(reset_n), .rf_addr(rf_addr),
    .rf_read(rf_read), .rf_rdata(rf_rdata), .tbl_addr(tbl_addr), .tbl_read(tbl_read),
    .tbl_rdata(tbl_rdata));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Present a word just after an edge; take() lets the next edge accept it; idle() drops it.
  // Valid is lowered only by idle(), so back-to-back words never toggle it in one step.
  task automatic present(input logic [15:0] w);
    insn_word = w;
    insn_valid = 1'b1;
    #1;
  endtask
  task automatic take();
    @(posedge clock);
    #2;
  endtask
  task automatic idle();
    insn_valid = 1'b0;
    @(posedge clock);
    #2;
  endtask
  task automatic send(input logic [15:0] w);
    present(w);
    take();
  endtask
  initial
  begin
    #(2000 * 25);
    errors++;
    end_sim();
  end
  initial
  begin
    reset_n = 1'b0;
    insn_valid = 1'b0;
    insn_word = 16'h0000;
    pin_levels = 8'h44;
    prescaler_assigned = 1'b1;
    repeat (10) @(posedge clock);
    #2;
    `CHK({working_register, status_flags, insn_ready}, 14'h0001)
    reset_n = 1'b1;
    idle();
    foreach (rows[i])
    begin
      send({8'h0e, rows[i][36:29]});
      send(rows[i][28:13]);
      `CHK({working_register, status_flags}, rows[i][12:0])
    end
    present(16'h0c5a);
    `CHK({return_pop, pipe_flush}, 2'b11)
    take();
    `CHK({working_register, status_flags, insn_ready}, 14'h16b4)
    idle();
    send(16'hf012);
    `CHK({working_register, rf_write}, 9'h0b4)
    send(16'h01ff);
    `CHK(bank_select_reg, 8'h0f)
    send(16'h0e10);
    send(16'h0d10);
    `CHK({product, working_register}, 24'h010010)
    send(16'hee15);
    send(16'hf0ab);
    `CHK(indirect_pointer_reg[23:12], 12'h5ab)
    present(16'h0623);
    `CHK({rf_read, rf_addr}, 13'h1023)
    take();
    `CHK({rf_write, rf_waddr, rf_wdata, status_flags}, {1'b1, 12'h023, 8'h78, 5'h03})
    send(16'h0680);
    `CHK({rf_waddr, rf_wdata}, 20'hf8043)
    present(16'hc123);
    `CHK({rf_read, rf_addr}, 13'h1123)
    take();
    `CHK(rf_write, 1'b0)
    send(16'hffd6);
    `CHK({rf_write, rf_waddr, rf_wdata, prescaler_clear}, 22'h3facf3)
    send(16'hc123);
    send(16'hfff9);
    `CHK({rf_write, status_flags}, 6'h03)
    prescaler_assigned = 1'b0;
    send(16'hc123);
    send(16'hffd6);
    `CHK({rf_write, prescaler_clear}, 2'b10)
    ptr = 21'h0;
    for (int m = 0; m < 8; m++)
    begin
      exp_addr = (m[1:0] == 2'h3) ? ptr + 21'h1 : ptr;
      present(16'h0008 | m[15:0]);
      `CHK({tbl_read, tbl_write, tbl_addr}, {~m[2], m[2], exp_addr})
      take();
      `CHK(insn_ready, 1'b0)
      idle();
      if (m[1:0] == 2'h1 || m[1:0] == 2'h3)
        ptr = ptr + 21'h1;
      else if (m[1:0] == 2'h2)
        ptr = ptr - 21'h1;
      `CHK(table_ptr, ptr)
      if (!m[2])
        `CHK(tbl_latch, exp_addr[7:0] ^ 8'h3c)
    end
    end_sim();
  end
endmodule
